// File: verilog/bsf_pkg.sv
// shared constants and types of the bit, shift and flag execution unit
package bsf_pkg;

   // bus geometry
   localparam int AXI_ADDR_W = 12;
   localparam int AXI_DATA_W = 32;

   // register byte offsets
   localparam logic [11:0] CMD_OFS = 12'h000;
   localparam logic [11:0] STAT_OFS = 12'h004;
   localparam logic [11:0] SLEEP_CFG_OFS = 12'h008;
   localparam logic [11:0] INFO_OFS = 12'h00c;
   localparam logic [3:0] WREG_PAGE = 4'h1;
   localparam logic [3:0] IO_PAGE = 4'h2;

   // command register fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_OP_W = 5;
   localparam int CMD_REG_LSB = 8;
   localparam int CMD_IDX_W = 5;
   localparam int CMD_BIT_LSB = 16;
   localparam int CMD_IO_LSB = 24;

   // info register fields
   localparam int INFO_BUSY_BIT = 0;
   localparam int INFO_CNT_LSB = 16;

   // status register bit positions
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_V = 3;
   localparam int FLG_S = 4;
   localparam int FLG_H = 5;
   localparam int FLG_T = 6;
   localparam int FLG_I = 7;

   // reset values
   localparam logic [7:0] STAT_RST = 8'h00;
   localparam logic [2:0] SLEEP_CFG_RST = 3'h0;

   // execution lengths in clock cycles
   localparam logic [1:0] IO_BIT_CYCLES = 2'h2;
   localparam logic [1:0] ONE_CYCLE = 2'h1;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;

   typedef enum logic [4:0] {
      no_op = 5'b00000,
      set_io_bit_op = 5'b00001,
      clear_io_bit_op = 5'b00010,
      logical_left_shift_op = 5'b00011,
      logical_right_shift_op = 5'b00100,
      rotate_left_carry_op = 5'b00101,
      rotate_right_carry_op = 5'b00110,
      arith_right_shift_op = 5'b00111,
      nibble_swap_op = 5'b01000,
      flag_set_op = 5'b01001,
      flag_clear_op = 5'b01010,
      bit_to_transfer_op = 5'b01011,
      transfer_to_bit_op = 5'b01100,
      carry_set_op = 5'b01101,
      carry_clear_op = 5'b01110,
      neg_set_op = 5'b01111,
      neg_clear_op = 5'b10000,
      zero_set_op = 5'b10001,
      zero_clear_op = 5'b10010,
      global_irq_on_op = 5'b10011,
      global_irq_off_op = 5'b10100,
      signed_set_op = 5'b10101,
      signed_clear_op = 5'b10110,
      ovf_set_op = 5'b10111,
      ovf_clear_op = 5'b11000,
      transfer_set_op = 5'b11001,
      transfer_clear_op = 5'b11010,
      half_set_op = 5'b11011,
      half_clear_op = 5'b11100,
      sleep_op = 5'b11101,
      watchdog_restart_op = 5'b11110
   } bsf_op_t;

   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_RUN = 1'b1
   } bsf_state_t;

   typedef enum logic [2:0] {
      K_CMD = 3'b000,
      K_STAT = 3'b001,
      K_SCFG = 3'b010,
      K_INFO = 3'b011,
      K_WREG = 3'b100,
      K_IO = 3'b101,
      K_NONE = 3'b110
   } bsf_kind_t;

endpackage

// File: verilog/bsf_alu.sv
// single-cycle shift, rotate, swap and flag datapath
`timescale 1ns/1ps
module bsf_alu import bsf_pkg::*; (
   input wire bsf_op_t op_i,
   input wire logic [7:0] opnd_i,
   input wire logic [2:0] bit_i,
   input wire logic [7:0] flags_i,
   output logic [7:0] res_o,
   output logic [7:0] flags_o,
   output logic wr_o
);

   logic shf;
   logic cout;

   // result and flag computation
   always_comb begin
      res_o = opnd_i;
      flags_o = flags_i;
      wr_o = 1'b0;
      shf = 1'b0;
      cout = flags_i[FLG_C];
      unique case (op_i)
         logical_left_shift_op: begin
            res_o = {opnd_i[6:0], 1'b0};
            cout = opnd_i[7];
            shf = 1'b1;
         end
         logical_right_shift_op: begin
            res_o = {1'b0, opnd_i[7:1]};
            cout = opnd_i[0];
            shf = 1'b1;
         end
         rotate_left_carry_op: begin
            res_o = {opnd_i[6:0], flags_i[FLG_C]};
            cout = opnd_i[7];
            shf = 1'b1;
         end
         rotate_right_carry_op: begin
            res_o = {flags_i[FLG_C], opnd_i[7:1]};
            cout = opnd_i[0];
            shf = 1'b1;
         end
         arith_right_shift_op: begin
            res_o = {opnd_i[7], opnd_i[7:1]};
            cout = opnd_i[0];
            shf = 1'b1;
         end
         nibble_swap_op: begin
            res_o = {opnd_i[3:0], opnd_i[7:4]};
            wr_o = 1'b1;
         end
         flag_set_op: flags_o[bit_i] = 1'b1;
         flag_clear_op: flags_o[bit_i] = 1'b0;
         bit_to_transfer_op: flags_o[FLG_T] = opnd_i[bit_i];
         transfer_to_bit_op: begin
            res_o[bit_i] = flags_i[FLG_T];
            wr_o = 1'b1;
         end
         carry_set_op: flags_o[FLG_C] = 1'b1;
         carry_clear_op: flags_o[FLG_C] = 1'b0;
         neg_set_op: flags_o[FLG_N] = 1'b1;
         neg_clear_op: flags_o[FLG_N] = 1'b0;
         zero_set_op: flags_o[FLG_Z] = 1'b1;
         zero_clear_op: flags_o[FLG_Z] = 1'b0;
         global_irq_on_op: flags_o[FLG_I] = 1'b1;
         global_irq_off_op: flags_o[FLG_I] = 1'b0;
         transfer_set_op: flags_o[FLG_T] = 1'b1;
         transfer_clear_op: flags_o[FLG_T] = 1'b0;
         signed_set_op: flags_o[FLG_S] = 1'b1;
         signed_clear_op: flags_o[FLG_S] = 1'b0;
         ovf_set_op: flags_o[FLG_V] = 1'b1;
         ovf_clear_op: flags_o[FLG_V] = 1'b0;
         half_set_op: flags_o[FLG_H] = 1'b1;
         half_clear_op: flags_o[FLG_H] = 1'b0;
         default: begin
         end
      endcase
      // shift family flag update
      if (shf) begin
         wr_o = 1'b1;
         flags_o[FLG_C] = cout;
         flags_o[FLG_Z] = (res_o == 8'h00);
         flags_o[FLG_N] = res_o[7];
         flags_o[FLG_V] = res_o[7] ^ cout;
      end
   end

endmodule

// File: verilog/bsf_exec_unit.sv
// bit, shift, flag and control execution unit with axi4-lite access
// Notes on behaviour
// - Setting an I/O bit forces that bit to one, touches no flag and takes two cycles.
// - Clearing an I/O bit forces that bit to zero, touches no flag and takes two cycles.
// - Shift left moves bits up, fills bit 0 with zero and updates Z, C, N and V in one cycle.
// - Shift right moves bits down, fills bit 7 with zero and updates Z, C, N and V in one cycle.
// - Rotate left puts old carry in bit 0, old bit 7 in carry and updates Z, C, N and V.
// - Rotate right puts old carry in bit 7, old bit 0 in carry and updates Z, C, N and V.
// - Arithmetic shift right keeps the sign bit and updates Z, C, N and V in one cycle.
// - Nibble swap exchanges the two halves of a register in one cycle with no flag change.
// - Generic flag set and clear write only the selected status bit in one cycle.
// - Bit store copies a register bit into the transfer flag and nothing else in one cycle.
// - Bit load copies the transfer flag into a register bit with no flag change in one cycle.
// - Half-carry set and clear change only that flag in one cycle.
// - Signed-test set and clear change only that flag in one cycle.
// - Overflow set and clear change only that flag in one cycle.
// - Sleep takes one cycle, requests the configured low-power mode and keeps all flags.
// - Watchdog restart takes one cycle, pulses the watchdog and keeps all flags.
`timescale 1ns/1ps
module bsf_exec_unit import bsf_pkg::*; #(
   parameter int NUM_WREGS = 32,
   parameter int NUM_IOREGS = 32
) (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic [11:0] S_AXI_AWADDR_I,
   input wire logic S_AXI_AWVALID_I,
   output logic S_AXI_AWREADY_O,
   input wire logic [31:0] S_AXI_WDATA_I,
   input wire logic [3:0] S_AXI_WSTRB_I,
   input wire logic S_AXI_WVALID_I,
   output logic S_AXI_WREADY_O,
   output logic [1:0] S_AXI_BRESP_O,
   output logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic [11:0] S_AXI_ARADDR_I,
   input wire logic S_AXI_ARVALID_I,
   output logic S_AXI_ARREADY_O,
   output logic [31:0] S_AXI_RDATA_O,
   output logic [1:0] S_AXI_RRESP_O,
   output logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   output logic [7:0] STATUS_O,
   output logic BUSY_O,
   output logic SLEEP_REQ_O,
   output logic [2:0] SLEEP_MODE_O,
   output logic WDT_RESTART_O
);

   // whole state of the unit
   typedef struct packed {
      // write side capture
      logic aw_have;
      logic [11:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;

      // bus answers
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;

      // operation sequencing
      logic [31:0] cmd;
      bsf_state_t state;
      logic [1:0] cnt;
      logic [7:0] io_tmp;

      // visible state
      logic [7:0] flags;
      logic [2:0] sleep_cfg;
      logic sleep_req;
      logic wdt_pulse;
      logic [15:0] op_count;

      // register files
      logic [NUM_WREGS-1:0][7:0] wreg;
      logic [NUM_IOREGS-1:0][7:0] io;
   } bsf_regs_t;

   bsf_regs_t r_reg;
   bsf_regs_t r_next;

   // decoded command fields
   bsf_op_t op;
   logic [CMD_IDX_W-1:0] reg_idx;
   logic [CMD_IDX_W-1:0] io_idx;
   logic [2:0] bit_sel;

   // index range checks
   logic reg_ok;
   logic io_ok;

   // datapath connections
   logic [7:0] opnd;
   logic [7:0] alu_res;
   logic [7:0] alu_flags;
   logic alu_wr;

   // register group per bus side
   bsf_kind_t wr_kind;
   bsf_kind_t rd_kind;

   // classify a byte address into a register group
   function automatic bsf_kind_t addr_kind(input logic [11:0] a);
      bsf_kind_t k;
      k = K_NONE;
      if (a[11:8] == 4'h0) begin
         // control registers on page zero
         unique case ({a[7:2], 2'b00})
            8'(CMD_OFS): k = K_CMD;
            8'(STAT_OFS): k = K_STAT;
            8'(SLEEP_CFG_OFS): k = K_SCFG;
            8'(INFO_OFS): k = K_INFO;
            default: k = K_NONE;
         endcase
      end else if (a[11:8] == WREG_PAGE && 32'(a[7:2]) < NUM_WREGS) begin
         k = K_WREG;
      end else if (a[11:8] == IO_PAGE && 32'(a[7:2]) < NUM_IOREGS) begin
         k = K_IO;
      end
      return k;
   endfunction

   // merge bus data into a word under the byte strobes
   function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      // copy each enabled lane
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            m[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return m;
   endfunction

   // cycles taken by an operation
   function automatic logic [1:0] op_cycles(input bsf_op_t o);
      logic [1:0] c;
      c = ONE_CYCLE;
      if (o == set_io_bit_op || o == clear_io_bit_op) begin
         c = IO_BIT_CYCLES;
      end
      return c;
   endfunction

   // command fields
   assign op = bsf_op_t'(r_reg.cmd[CMD_OP_LSB +: CMD_OP_W]);
   assign reg_idx = r_reg.cmd[CMD_REG_LSB +: CMD_IDX_W];
   assign io_idx = r_reg.cmd[CMD_IO_LSB +: CMD_IDX_W];
   assign bit_sel = r_reg.cmd[CMD_BIT_LSB +: 3];
   // range checks and operand
   assign reg_ok = 32'(reg_idx) < NUM_WREGS;
   assign io_ok = 32'(io_idx) < NUM_IOREGS;
   assign opnd = reg_ok ? r_reg.wreg[reg_idx] : 8'h00;
   // register group addressed
   assign wr_kind = addr_kind(r_reg.aw_addr);
   assign rd_kind = addr_kind(S_AXI_ARADDR_I);

   // shift, swap and flag datapath
   bsf_alu u_alu (
      .op_i(op),
      .opnd_i(opnd),
      .bit_i(bit_sel),
      .flags_i(r_reg.flags),
      .res_o(alu_res),
      .flags_o(alu_flags),
      .wr_o(alu_wr)
   );

   // bus handshake outputs
   assign S_AXI_AWREADY_O = !r_reg.aw_have;
   assign S_AXI_WREADY_O = !r_reg.w_have;
   assign S_AXI_ARREADY_O = !r_reg.rvalid;

   // answer channels from flip-flops
   assign S_AXI_BVALID_O = r_reg.bvalid;
   assign S_AXI_BRESP_O = r_reg.bresp;
   assign S_AXI_RVALID_O = r_reg.rvalid;
   assign S_AXI_RDATA_O = r_reg.rdata;
   assign S_AXI_RRESP_O = r_reg.rresp;

   // unit outputs
   assign STATUS_O = r_reg.flags;
   assign BUSY_O = (r_reg.state == ST_RUN);
   assign SLEEP_REQ_O = r_reg.sleep_req;
   assign SLEEP_MODE_O = r_reg.sleep_cfg;
   assign WDT_RESTART_O = r_reg.wdt_pulse;

   // next-state logic
   always_comb begin
      r_next = r_reg;
      // pulses last one cycle
      r_next.sleep_req = 1'b0;
      r_next.wdt_pulse = 1'b0;

      // capture write address and data, in either order
      if (S_AXI_AWVALID_I && !r_reg.aw_have) begin
         r_next.aw_have = 1'b1;
         r_next.aw_addr = S_AXI_AWADDR_I;
      end
      if (S_AXI_WVALID_I && !r_reg.w_have) begin
         r_next.w_have = 1'b1;
         r_next.w_data = S_AXI_WDATA_I;
         r_next.w_strb = S_AXI_WSTRB_I;
      end

      // write response handshake
      if (r_reg.bvalid && S_AXI_BREADY_I) begin
         r_next.bvalid = 1'b0;
      end

      // perform a held write once the unit is idle
      if (r_reg.aw_have && r_reg.w_have && !r_reg.bvalid && r_reg.state == ST_IDLE) begin
         r_next.aw_have = 1'b0;
         r_next.w_have = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = RESP_OKAY;
         unique case (wr_kind)
            K_CMD: begin
               r_next.cmd = strb_merge(r_reg.cmd, r_reg.w_data, r_reg.w_strb);
               // opcode lane written starts the operation
               if (r_reg.w_strb[0]) begin
                  r_next.state = ST_RUN;
                  r_next.cnt = 2'h0;
               end
            end
            K_STAT: begin
               if (r_reg.w_strb[0]) begin
                  r_next.flags = r_reg.w_data[7:0];
               end
            end
            K_SCFG: begin
               if (r_reg.w_strb[0]) begin
                  r_next.sleep_cfg = r_reg.w_data[2:0];
               end
            end
            K_WREG: begin
               if (r_reg.w_strb[0]) begin
                  r_next.wreg[r_reg.aw_addr[7:2]] = r_reg.w_data[7:0];
               end
            end
            K_IO: begin
               if (r_reg.w_strb[0]) begin
                  r_next.io[r_reg.aw_addr[7:2]] = r_reg.w_data[7:0];
               end
            end
            K_INFO: begin
               // read-only, write ignored
            end
            // unmapped: error, no effect
            default: r_next.bresp = RESP_DECERR;
         endcase
      end

      // read channel
      if (r_reg.rvalid && S_AXI_RREADY_I) begin
         r_next.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID_I && !r_reg.rvalid) begin
         r_next.rvalid = 1'b1;
         r_next.rresp = RESP_OKAY;
         r_next.rdata = 32'h0000_0000;
         unique case (rd_kind)
            K_CMD: r_next.rdata = r_reg.cmd;
            K_STAT: r_next.rdata[7:0] = r_reg.flags;
            K_SCFG: r_next.rdata[2:0] = r_reg.sleep_cfg;
            K_INFO: begin
               r_next.rdata[INFO_BUSY_BIT] = (r_reg.state == ST_RUN);
               r_next.rdata[INFO_CNT_LSB +: 16] = r_reg.op_count;
            end
            K_WREG: r_next.rdata[7:0] = r_reg.wreg[S_AXI_ARADDR_I[7:2]];
            K_IO: r_next.rdata[7:0] = r_reg.io[S_AXI_ARADDR_I[7:2]];
            // unmapped read answers an error
            default: r_next.rresp = RESP_DECERR;
         endcase
      end

      // operation execution
      if (r_reg.state == ST_RUN) begin
         // step counter
         r_next.cnt = 2'(r_reg.cnt + 2'h1);
         unique case (op)
            set_io_bit_op, clear_io_bit_op: begin
               // first cycle fetches the i/o register
               if (r_reg.cnt == 2'h0) begin
                  r_next.io_tmp = io_ok ? r_reg.io[io_idx] : 8'h00;
               end else if (io_ok) begin
                  // second cycle writes back
                  r_next.io[io_idx] = r_reg.io_tmp;
                  if (op == set_io_bit_op) begin
                     r_next.io[io_idx][bit_sel] = 1'b1;
                  end else begin
                     r_next.io[io_idx][bit_sel] = 1'b0;
                  end
               end
            end
            no_op: begin
            end
            sleep_op: r_next.sleep_req = 1'b1;
            watchdog_restart_op: r_next.wdt_pulse = 1'b1;
            default: begin
               // flags and results only from the datapath
               r_next.flags = alu_flags;
               if (alu_wr && reg_ok) begin
                  r_next.wreg[reg_idx] = alu_res;
               end
            end
         endcase
         // finish after the operation's cycle count
         if (r_reg.cnt == 2'(op_cycles(op) - 2'h1)) begin
            r_next.state = ST_IDLE;
            r_next.cnt = 2'h0;
            // count for the info register
            r_next.op_count = 16'(r_reg.op_count + 16'h0001);
         end
      end
   end

   // state register
   always_ff @(posedge REF_CLK_I) begin
      // synchronous reset to constants
      if (!RST_N_I) begin
         r_reg <= '0;
         r_reg.state <= ST_IDLE;
         r_reg.flags <= STAT_RST;
         r_reg.sleep_cfg <= SLEEP_CFG_RST;
      end else begin
         // take the next state
         r_reg <= r_next;
      end
   end

endmodule

// File: dv/bsf_exec_unit_assertions.sv
// port-level property checker for the bit, shift and flag unit
`timescale 1ns/1ps
module bsf_exec_chk (
   input wire logic REF_CLK_I,
   input wire logic RST_N_I,
   input wire logic S_AXI_AWVALID_I,
   input wire logic S_AXI_AWREADY_O,
   input wire logic [1:0] S_AXI_BRESP_O,
   input wire logic S_AXI_BVALID_O,
   input wire logic S_AXI_BREADY_I,
   input wire logic S_AXI_ARVALID_I,
   input wire logic S_AXI_ARREADY_O,
   input wire logic [31:0] S_AXI_RDATA_O,
   input wire logic S_AXI_RVALID_O,
   input wire logic S_AXI_RREADY_I,
   input wire logic [7:0] STATUS_O,
   input wire logic BUSY_O,
   input wire logic SLEEP_REQ_O,
   input wire logic WDT_RESTART_O
);
   default clocking cb @(posedge REF_CLK_I);
   endclocking
   default disable iff (!RST_N_I);

   // read answer one cycle after the address
   property p_rd_answer;
      S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O;
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
   // answers stand until taken
   property p_rd_hold;
      S_AXI_RVALID_O && !S_AXI_RREADY_I |=> S_AXI_RVALID_O && $stable(S_AXI_RDATA_O);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data dropped");
   property p_wr_hold;
      S_AXI_BVALID_O && !S_AXI_BREADY_I |=> S_AXI_BVALID_O && $stable(S_AXI_BRESP_O);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write response dropped");
   // a taken address blocks the next one
   property p_aw_block;
      S_AXI_AWVALID_I && S_AXI_AWREADY_O |=> !S_AXI_AWREADY_O;
   endproperty
   a_aw_block: assert property (p_aw_block) else $error("address ready stayed high");
   // writes are only performed while idle
   property p_wr_idle;
      $rose(S_AXI_BVALID_O) |-> !$past(BUSY_O);
   endproperty
   a_wr_idle: assert property (p_wr_idle) else $error("write performed while busy");
   // no operation runs longer than two cycles
   property p_busy_len;
      $rose(BUSY_O) |-> ##[1:2] !BUSY_O;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("operation too long");
   // sleep request is a single pulse at the end of the op
   property p_sleep_pulse;
      SLEEP_REQ_O |-> ($past(BUSY_O) && !BUSY_O) ##1 !SLEEP_REQ_O;
   endproperty
   a_sleep_pulse: assert property (p_sleep_pulse) else $error("sleep pulse shape");
   property p_sleep_flags;
      SLEEP_REQ_O |-> $stable(STATUS_O);
   endproperty
   a_sleep_flags: assert property (p_sleep_flags) else $error("sleep changed flags");
   // watchdog restart is a single pulse at the end of the op
   property p_wdt_pulse;
      WDT_RESTART_O |-> ($past(BUSY_O) && !BUSY_O) ##1 !WDT_RESTART_O;
   endproperty
   a_wdt_pulse: assert property (p_wdt_pulse) else $error("restart pulse shape");
   property p_wdt_flags;
      WDT_RESTART_O |-> $stable(STATUS_O);
   endproperty
   a_wdt_flags: assert property (p_wdt_flags) else $error("restart changed flags");
endmodule

// File: dv/tb_bit_shift_flag_exec_unit.sv
// self-checking bench for the bit, shift and flag unit
`timescale 1ns/1ps
module tb_bit_shift_flag_exec_unit import bsf_pkg::*; ;
   typedef struct {
      bsf_op_t op;
      logic [7:0] a;
      logic [2:0] b;
      logic [7:0] s;
      logic [7:0] r;
      logic [7:0] f;
   } bsf_row_t;
   // op, operand, bit, flags in, result, flags out
   bsf_row_t rows[14] = '{
      '{logical_left_shift_op, 8'h81, 3'h0, 8'h00, 8'h02, 8'h09},
      '{logical_left_shift_op, 8'h80, 3'h0, 8'h00, 8'h00, 8'h0b},
      '{logical_right_shift_op, 8'h01, 3'h0, 8'hf0, 8'h00, 8'hfb},
      '{rotate_left_carry_op, 8'h40, 3'h0, 8'h01, 8'h81, 8'h0c},
      '{rotate_right_carry_op, 8'h02, 3'h0, 8'h01, 8'h81, 8'h0c},
      '{arith_right_shift_op, 8'h83, 3'h0, 8'h00, 8'hc1, 8'h05},
      '{nibble_swap_op, 8'h1e, 3'h0, 8'h5a, 8'he1, 8'h5a},
      '{flag_set_op, 8'h55, 3'h5, 8'h00, 8'h55, 8'h20},
      '{flag_clear_op, 8'h55, 3'h7, 8'hff, 8'h55, 8'h7f},
      '{bit_to_transfer_op, 8'h10, 3'h4, 8'h00, 8'h10, 8'h40},
      '{transfer_to_bit_op, 8'h00, 3'h2, 8'h40, 8'h04, 8'h40},
      '{no_op, 8'h3c, 3'h0, 8'ha5, 8'h3c, 8'ha5},
      '{sleep_op, 8'h3c, 3'h0, 8'h33, 8'h3c, 8'h33},
      '{watchdog_restart_op, 8'h3c, 3'h0, 8'h33, 8'h3c, 8'h33}};
   // flag position of shorthand ops C N Z I S V T H
   int pos[8] = '{0, 2, 1, 7, 4, 3, 6, 5};
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, busy, slp, wdt;
   logic [1:0] bresp, rresp, rd_r;
   logic [31:0] rdata, rd_v;
   logic [7:0] status, m;
   logic [2:0] smode;
   int n_fail = 0, tests_run = 0, busy_cnt = 0, slp_cnt = 0, wdt_cnt = 0;
   int d_busy, d_slp, d_wdt;

   always #12.5 ref_clk = ~ref_clk;

   bsf_exec_unit DUT (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .S_AXI_AWADDR_I(awaddr),
      .S_AXI_AWVALID_I(awvalid), .S_AXI_AWREADY_O(awready), .S_AXI_WDATA_I(wdata),
      .S_AXI_WSTRB_I(wstrb), .S_AXI_WVALID_I(wvalid), .S_AXI_WREADY_O(wready),
      .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bvalid), .S_AXI_BREADY_I(bready),
      .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arvalid), .S_AXI_ARREADY_O(arready),
      .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rvalid),
      .S_AXI_RREADY_I(rready), .STATUS_O(status), .BUSY_O(busy), .SLEEP_REQ_O(slp),
      .SLEEP_MODE_O(smode), .WDT_RESTART_O(wdt));

   // counts busy cycles and pulses
   always @(posedge ref_clk) begin
      if (busy === 1'b1) busy_cnt++;
      if (slp === 1'b1) slp_cnt++;
      if (wdt === 1'b1) wdt_cnt++;
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask

   task finish_test;
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // bus write; address and data offered together
   task axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
               input logic [1:0] er);
      logic haw, hw, hb;
      int t;
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      hb = 1'b0;
      t = 0;
      while (!hb && t < 200) begin
         #1;
         haw = awvalid & awready;
         hw = wvalid & wready;
         hb = (bvalid === 1'b1);
         rd_r = bresp;
         @(posedge ref_clk);
         if (haw) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
         t++;
      end
      bready <= 1'b0;
      #1;
      chk(hb, 1'b1);
      chk(rd_r, er);
   endtask

   task axi_rd(input logic [11:0] a);
      logic har, hr;
      int t;
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      hr = 1'b0;
      t = 0;
      while (!hr && t < 200) begin
         #1;
         har = arvalid & arready;
         hr = (rvalid === 1'b1);
         rd_v = rdata;
         rd_r = rresp;
         @(posedge ref_clk);
         if (har) arvalid <= 1'b0;
         t++;
      end
      rready <= 1'b0;
      #1;
      chk(hr, 1'b1);
   endtask

   // command write, then wait for the unit to go idle
   task run_op(input logic [4:0] op, input logic [4:0] r, input logic [2:0] b,
               input logic [4:0] io);
      int b0, s0, w0, t;
      b0 = busy_cnt;
      s0 = slp_cnt;
      w0 = wdt_cnt;
      axi_wr(CMD_OFS, {3'h0, io, 5'h0, b, 3'h0, r, 3'h0, op}, 4'hf, RESP_OKAY);
      t = 0;
      while (busy === 1'b1 && t < 20) begin
         @(posedge ref_clk);
         #1;
         t++;
      end
      @(posedge ref_clk);
      #1;
      chk(busy, 1'b0);
      d_busy = busy_cnt - b0;
      d_slp = slp_cnt - s0;
      d_wdt = wdt_cnt - w0;
   endtask

   // hang guard
   initial begin
      #(25 * 8000);
      n_fail++;
      finish_test;
   end

   initial begin
      repeat (16) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk(status, STAT_RST);
      chk(smode, SLEEP_CFG_RST);
      axi_rd(12'h10c);
      chk(rd_v, 32'h0);
      $display("test reset values done");
      // shifts, swap, generic flag ops, bit moves, no-op, sleep, restart
      for (int i = 0; i < 14; i++) begin
         axi_wr(12'h10c, {24'h0, rows[i].a}, 4'h1, RESP_OKAY);
         axi_wr(STAT_OFS, {24'h0, rows[i].s}, 4'h1, RESP_OKAY);
         run_op(rows[i].op, 5'h3, rows[i].b, 5'h0);
         axi_rd(12'h10c);
         chk(rd_r, RESP_OKAY);
         chk(rd_v, {24'h0, rows[i].r});
         chk(status, rows[i].f);
         chk(d_busy, 1);
         chk(d_slp, rows[i].op == sleep_op);
         chk(d_wdt, rows[i].op == watchdog_restart_op);
      end
      $display("test row table done");
      // shorthand set and clear of each single flag
      for (int k = 0; k < 8; k++) begin
         m = 8'h01 << pos[k];
         axi_wr(STAT_OFS, 32'h0, 4'h1, RESP_OKAY);
         run_op(5'(13 + 2 * k), 5'h3, 3'h0, 5'h0);
         chk(status, m);
         axi_wr(STAT_OFS, 32'hff, 4'h1, RESP_OKAY);
         run_op(5'(14 + 2 * k), 5'h3, 3'h0, 5'h0);
         chk(status, m ^ 8'hff);
         chk(d_busy, 1);
      end
      $display("test shorthand flags done");
      // top i/o register, two-cycle set of top bit and clear of bit 1
      axi_wr(STAT_OFS, 32'h81, 4'h1, RESP_OKAY);
      axi_wr(12'h27c, 32'h5a, 4'h1, RESP_OKAY);
      run_op(set_io_bit_op, 5'h0, 3'h7, 5'h1f);
      chk(d_busy, 2);
      axi_rd(12'h27c);
      chk(rd_v, 32'hda);
      chk(status, 8'h81);
      run_op(clear_io_bit_op, 5'h0, 3'h1, 5'h1f);
      chk(d_busy, 2);
      axi_rd(12'h27c);
      chk(rd_v, 32'hd8);
      chk(status, 8'h81);
      // 32 ops so far, unit idle
      axi_rd(INFO_OFS);
      chk(rd_v, 32'h0020_0000);
      $display("test io bits done");
      // sleep mode level and unmapped place
      axi_wr(SLEEP_CFG_OFS, 32'h5, 4'h1, RESP_OKAY);
      chk(smode, 3'h5);
      axi_wr(12'h010, 32'h1, 4'hf, RESP_DECERR);
      axi_rd(12'h010);
      chk(rd_r, RESP_DECERR);
      $display("test bus map done");
      // second reset in mid-run
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      #1;
      chk(status, STAT_RST);
      chk(smode, SLEEP_CFG_RST);
      chk(busy, 1'b0);
      axi_rd(12'h27c);
      chk(rd_v, 32'h0);
      $display("test mid-run reset done");
      finish_test;
   end
endmodule

bind bsf_exec_unit bsf_exec_chk u_chk (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
   .S_AXI_AWVALID_I(S_AXI_AWVALID_I), .S_AXI_AWREADY_O(S_AXI_AWREADY_O),
   .S_AXI_BRESP_O(S_AXI_BRESP_O), .S_AXI_BVALID_O(S_AXI_BVALID_O),
   .S_AXI_BREADY_I(S_AXI_BREADY_I), .S_AXI_ARVALID_I(S_AXI_ARVALID_I),
   .S_AXI_ARREADY_O(S_AXI_ARREADY_O), .S_AXI_RDATA_O(S_AXI_RDATA_O),
   .S_AXI_RVALID_O(S_AXI_RVALID_O), .S_AXI_RREADY_I(S_AXI_RREADY_I), .STATUS_O(STATUS_O),
   .BUSY_O(BUSY_O), .SLEEP_REQ_O(SLEEP_REQ_O), .WDT_RESTART_O(WDT_RESTART_O));
